// [mtab_chan_a.sv]
module mtab_chan_a
  import mtab_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       mode,
  input  wire logic             count_up,
  input  wire logic             free_run,
  input  wire logic             start,
  input  wire logic             event_tick,
  input  wire logic             load_wr,
  input  wire logic [CNT_W-1:0] load_data,
  output logic      [CNT_W-1:0] count,
  output logic                  reload_evt,
  output logic                  irq_evt,
  output logic                  pin_out
);

  if (CNT_W < 2) begin : g_chk
    $error("mtab_chan_a: CNT_W must be at least 2");
  end

  logic [CNT_W-1:0] cnt_ff, nxt_cnt, reload_ff;
  logic             out_ff, nxt_out, run_ff, nxt_run, start_d_ff;

  // Edges of the start flag and the count tick of the current mode
  wire start_rise = start & ~start_d_ff;
  wire start_fall = ~start & start_d_ff;
  wire is_cnt     = (mode == A_TIMER) | (mode == A_EVENT);
  wire up         = (mode == A_EVENT) & count_up;
  wire tick       = (mode == A_EVENT) ? event_tick : 1'b1;
  wire at_end     = up ? (&cnt_ff) : (cnt_ff == '0);
  wire pwm_high   = cnt_ff < reload_ff;

  // Free-run event counting wraps instead of reloading
  assign reload_evt = is_cnt & start & tick & at_end & ~((mode == A_EVENT) & free_run);
  assign count      = cnt_ff;
  assign pin_out    = out_ff;

  // Next counter, output and one-shot state per mode
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    nxt_run = run_ff;
    irq_evt = 1'b0;
    unique case (mode)
      A_TIMER, A_EVENT: begin
        nxt_out = 1'b0;
        if (start & tick) begin
          irq_evt = at_end;
          if (reload_evt) nxt_cnt = reload_ff;
          else nxt_cnt = up ? cnt_ff + 1'b1 : cnt_ff - 1'b1;
        end
      end
      A_ONESHOT: begin
        if (start_fall & run_ff) begin
          nxt_run = 1'b0;
          nxt_cnt = reload_ff;
          nxt_out = 1'b0;
          irq_evt = 1'b1;
        end else if (start_rise) begin
          nxt_run = 1'b1;
          nxt_cnt = reload_ff;
          nxt_out = 1'b1;
        end else if (run_ff & start) begin
          if (cnt_ff == '0) begin
            nxt_run = 1'b0;
            nxt_out = 1'b0;
            nxt_cnt = reload_ff;
            irq_evt = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
      end
      A_PWM: begin
        nxt_run = 1'b0;
        if (start_fall) begin
          nxt_out = 1'b0;
          irq_evt = out_ff;
        end else if (start_rise) begin
          nxt_cnt = '0;
        end else if (start) begin
          nxt_cnt = cnt_ff + 1'b1;
          nxt_out = pwm_high;
          irq_evt = out_ff & ~pwm_high;
        end
      end
    endcase
    // A write while halted loads the counter so it reads back at once
    if (load_wr & ~start) nxt_cnt = load_data;
  end

  // Channel state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff     <= '0;
      reload_ff  <= '0;
      out_ff     <= 1'b0;
      run_ff     <= 1'b0;
      start_d_ff <= 1'b0;
    end else begin
      cnt_ff     <= nxt_cnt;
      out_ff     <= nxt_out;
      run_ff     <= nxt_run;
      start_d_ff <= start;
      if (load_wr) reload_ff <= load_data;
    end
  end

  oneshot_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == A_ONESHOT) & start_fall & run_ff |-> irq_evt ##1 (!out_ff && cnt_ff == reload_ff))
    else $error("one-shot stop did not reload, drop output and request");
  pwm_stop_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == A_PWM) & start_fall & out_ff & ~load_wr |-> irq_evt ##1 (!out_ff && $stable(cnt_ff)))
    else $error("PWM stop with high output misbehaved");
  pwm_stop_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == A_PWM) & start_fall & !out_ff |-> !irq_evt ##1 !out_ff)
    else $error("PWM stop with low output changed level or requested");

endmodule : mtab_chan_a

// [mtab_chan_b.sv]
module mtab_chan_b
  import mtab_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       mode,
  input  wire logic             width_sel,
  input  wire logic             start,
  input  wire logic             edge_rise,
  input  wire logic             edge_fall,
  input  wire logic             load_wr,
  input  wire logic [CNT_W-1:0] load_data,
  output logic      [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] reload,
  output logic                  reload_evt,
  output logic                  irq_evt
);

  if (CNT_W < 2) begin : g_chk
    $error("mtab_chan_b: CNT_W must be at least 2");
  end

  logic [CNT_W-1:0] cnt_ff, reload_ff;
  logic             first_ff, start_d_ff;

  // Width measurement takes both edges, period measurement rising only
  wire meas      = (mode == B_MEAS);
  wire start_rise = start & ~start_d_ff;
  wire eff_edge  = width_sel ? (edge_rise | edge_fall) : edge_rise;
  wire tick      = (mode == B_EVENT) ? edge_rise : 1'b1;
  wire cnt_run   = ~meas & start & tick;

  assign reload_evt = cnt_run & (cnt_ff == '0);
  // The first edge captures and restarts the count, but raises nothing
  assign irq_evt    = reload_evt | (meas & start & ~start_rise & eff_edge & ~first_ff);
  assign count      = cnt_ff;
  assign reload     = reload_ff;

  // Counter, capture register and first-edge marker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff     <= '0;
      reload_ff  <= '0;
      first_ff   <= 1'b0;
      start_d_ff <= 1'b0;
    end else begin
      start_d_ff <= start;
      if (meas & start_rise) begin
        cnt_ff   <= '0;
        first_ff <= 1'b1;
      end else if (meas & start & eff_edge) begin
        reload_ff <= cnt_ff;
        cnt_ff    <= '0;
        first_ff  <= 1'b0;
      end else if (meas & start) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (reload_evt) begin
        cnt_ff <= reload_ff;
      end else if (cnt_run) begin
        cnt_ff <= cnt_ff - 1'b1;
      end else if (load_wr & ~start) begin
        cnt_ff <= load_data;
      end
      if (load_wr & ~meas) reload_ff <= load_data;
    end
  end

  first_edge_b_a: assert property (@(posedge clk) disable iff (!rst_n)
    meas & start & ~start_rise & eff_edge & first_ff |-> !irq_evt ##1 (reload_ff == $past(cnt_ff)))
    else $error("first measured edge raised a request or skipped capture");

endmodule : mtab_chan_b

// [mtab_pkg.sv]
package mtab_pkg;

  // Counter width shared by both channels
  localparam int TMR_W = 16;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_START    = 8'h00;
  localparam logic [7:0] OFS_A_MODE   = 8'h04;
  localparam logic [7:0] OFS_A_TIMER  = 8'h08;
  localparam logic [7:0] OFS_B_MODE   = 8'h0C;
  localparam logic [7:0] OFS_B_TIMER  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // Bit positions in the start, status and mask registers
  localparam int CH_A_BIT = 0;
  localparam int CH_B_BIT = 1;

  // Field positions in the mode registers
  localparam int MODE_LSB    = 0;
  localparam int A_UP_BIT    = 2;
  localparam int A_FREE_BIT  = 3;
  localparam int B_WIDTH_BIT = 2;

  // Operating mode codes of the A-type channel
  localparam logic [1:0] A_TIMER   = 2'h0;
  localparam logic [1:0] A_EVENT   = 2'h1;
  localparam logic [1:0] A_ONESHOT = 2'h2;
  localparam logic [1:0] A_PWM     = 2'h3;

  // Operating mode codes of the B-type channel
  localparam logic [1:0] B_TIMER = 2'h0;
  localparam logic [1:0] B_EVENT = 2'h1;
  localparam logic [1:0] B_MEAS  = 2'h2;

  // Reset values
  localparam logic [1:0]       RST_START  = 2'h0;
  localparam logic [3:0]       RST_A_MODE = 4'h0;
  localparam logic [2:0]       RST_B_MODE = 3'h0;
  localparam logic [1:0]       RST_IRQ    = 2'h0;
  localparam logic [TMR_W-1:0] RST_COUNT  = 16'h0000;

  // Values a counter read returns at the reload moment
  localparam logic [TMR_W-1:0] RD_AT_UNDER = 16'hFFFF;
  localparam logic [TMR_W-1:0] RD_AT_OVER  = 16'h0000;

endpackage : mtab_pkg

// [mtab_timer.sv]
module mtab_timer
  import mtab_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        a_event_pin,
  input  wire logic        b_event_pin,
  output logic             timer_a_output_pin,
  output logic             irq
);

  logic [1:0]       rst_sync_ff;
  logic [2:0]       a_pin_ff, b_pin_ff;
  logic             dph_ff, wr_ff, hready_ff, hresp_ff, irq_ff;
  logic [7:0]       addr_ff;
  logic [31:0]      hrdata_ff;
  logic [1:0]       start_ff, irq_stat_ff, irq_mask_ff, nxt_irq_stat;
  logic [3:0]       a_mode_ff;
  logic [2:0]       b_mode_ff;
  logic [TMR_W-1:0] a_count, b_count, b_reload;
  logic             a_reload_evt, a_irq_evt, a_out;
  logic             b_reload_evt, b_irq_evt;

  // Reset is released through two flops so every flop leaves reset together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  wire rst_sync_n = rst_sync_ff[1];

  // Event pins cross in two stages; the third stage is only for edges
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      a_pin_ff <= 3'h0;
      b_pin_ff <= 3'h0;
    end else begin
      a_pin_ff <= {a_pin_ff[1:0], a_event_pin};
      b_pin_ff <= {b_pin_ff[1:0], b_event_pin};
    end
  end
  wire a_rise = a_pin_ff[1] & ~a_pin_ff[2];
  wire b_rise = b_pin_ff[1] & ~b_pin_ff[2];
  wire b_fall = ~b_pin_ff[1] & b_pin_ff[2];

  // Bus address phase is taken when selected, non-idle and the bus is ready
  wire addr_take = hsel & htrans[1] & hready;
  wire wr_go     = dph_ff & wr_ff;
  wire rd_go     = dph_ff & ~wr_ff;

  // One wait state so read data can leave from a flop
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dph_ff    <= 1'b0;
      wr_ff     <= 1'b0;
      addr_ff   <= 8'h00;
      hready_ff <= 1'b1;
      hresp_ff  <= 1'b0;
    end else if (addr_take) begin
      dph_ff    <= 1'b1;
      wr_ff     <= hwrite;
      addr_ff   <= haddr[7:0];
      hready_ff <= 1'b0;
    end else if (dph_ff) begin
      dph_ff    <= 1'b0;
      hready_ff <= 1'b1;
    end
  end

  // Every transfer gets exactly one wait state
  bus_wait_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    addr_take
    |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take one wait state");

  // Register decode; any other offset reads zero and ignores writes
  wire sel_start = addr_ff == OFS_START;
  wire sel_amode = addr_ff == OFS_A_MODE;
  wire sel_atmr  = addr_ff == OFS_A_TIMER;
  wire sel_bmode = addr_ff == OFS_B_MODE;
  wire sel_btmr  = addr_ff == OFS_B_TIMER;
  wire sel_stat  = addr_ff == OFS_IRQ_STAT;
  wire sel_mask  = addr_ff == OFS_IRQ_MASK;

  wire [1:0] a_mode     = a_mode_ff[MODE_LSB+:2];
  wire [1:0] b_mode     = b_mode_ff[MODE_LSB+:2];
  wire [1:0] a_new_mode = hwdata[MODE_LSB+:2];
  wire       a_load_wr  = wr_go & sel_atmr;
  wire       b_load_wr  = wr_go & sel_btmr;
  wire       a_up       = (a_mode == A_EVENT) & a_mode_ff[A_UP_BIT];

  // Leaving timer or event mode for one-shot or PWM raises a stray request
  wire a_from_cnt = (a_mode == A_TIMER) | (a_mode == A_EVENT);
  wire a_mode_irq = wr_go & sel_amode & a_from_cnt
                  & ((a_new_mode == A_ONESHOT) | (a_new_mode == A_PWM));

  // Flipping period/width select mid-measurement raises a request
  wire b_sel_irq = wr_go & sel_bmode & start_ff[CH_B_BIT] & (b_mode == B_MEAS)
                 & (hwdata[B_WIDTH_BIT] != b_mode_ff[B_WIDTH_BIT]);

  // Sticky status: a new event wins over a write-one clear
  wire [1:0] irq_set = {b_irq_evt | b_sel_irq, a_irq_evt | a_mode_irq};
  wire [1:0] irq_clr = (wr_go & sel_stat) ? hwdata[1:0] : 2'h0;
  assign nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);

  // Counter reads give the fixed value at the reload moment
  wire [TMR_W-1:0] a_rd = a_reload_evt ? (a_up ? RD_AT_OVER : RD_AT_UNDER)
                                       : a_count;
  wire [TMR_W-1:0] b_rd = (b_mode == B_MEAS) ? b_reload
                        : (b_reload_evt ? RD_AT_UNDER : b_count);

  wire [31:0] rd_mux = sel_start ? {30'h0, start_ff}
                     : sel_amode ? {28'h0, a_mode_ff}
                     : sel_atmr  ? {16'h0, a_rd}
                     : sel_bmode ? {29'h0, b_mode_ff}
                     : sel_btmr  ? {16'h0, b_rd}
                     : sel_stat  ? {30'h0, irq_stat_ff}
                     : sel_mask  ? {30'h0, irq_mask_ff}
                     : 32'h0;

  // Software-visible registers
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_ff    <= RST_START;
      a_mode_ff   <= RST_A_MODE;
      b_mode_ff   <= RST_B_MODE;
      irq_mask_ff <= RST_IRQ;
    end else if (wr_go) begin
      if (sel_start) start_ff <= hwdata[1:0];
      if (sel_amode) a_mode_ff <= hwdata[3:0];
      if (sel_bmode) b_mode_ff <= hwdata[2:0];
      if (sel_mask) irq_mask_ff <= hwdata[1:0];
    end
  end

  // Status, interrupt level and read data
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat_ff <= RST_IRQ;
      irq_ff      <= 1'b0;
      hrdata_ff   <= 32'h0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
      if (rd_go) hrdata_ff <= rd_mux;
    end
  end

  // Read data hold until the next read completes
  rd_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    !rd_go
    |=> $stable(hrdata))
    else $error("read data changed without a read");
  // Level lags a mask write by a cycle, never a status change
  irq_level_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    1'b1
    |-> irq == |(irq_stat_ff & $past(irq_mask_ff)))
    else $error("interrupt level disagrees with status and mask");
  // A set status bit stays until a one is written to it
  sticky_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    irq_stat_ff[CH_A_BIT] & ~irq_clr[CH_A_BIT]
    |=> irq_stat_ff[CH_A_BIT])
    else $error("A status dropped without a clear");
  b_sticky_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    irq_stat_ff[CH_B_BIT] & ~irq_clr[CH_B_BIT]
    |=> irq_stat_ff[CH_B_BIT])
    else $error("B status dropped without a clear");
  // A B event always lands, even against a clear
  b_sticky_set_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    irq_set[CH_B_BIT]
    |=> irq_stat_ff[CH_B_BIT])
    else $error("B event lost against a clear");
  // Writing a one clears a quiet status bit
  stat_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    wr_go & sel_stat & hwdata[CH_A_BIT] & ~irq_set[CH_A_BIT]
    |=> !irq_stat_ff[CH_A_BIT])
    else $error("A status not cleared by a written one");
  // Control writes land whole
  mode_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    wr_go & sel_amode
    |=> a_mode_ff == $past(hwdata[3:0]))
    else $error("A mode write lost");
  start_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    wr_go & sel_start
    |=> start_ff == $past(hwdata[1:0]))
    else $error("start write lost");

  mtab_chan_a #(
    .CNT_W (TMR_W)
  ) u_chan_a (
    .clk        (sys_clk),
    .rst_n      (rst_sync_n),
    .mode       (a_mode),
    .count_up   (a_mode_ff[A_UP_BIT]),
    .free_run   (a_mode_ff[A_FREE_BIT]),
    .start      (start_ff[CH_A_BIT]),
    .event_tick (a_rise),
    .load_wr    (a_load_wr),
    .load_data  (hwdata[TMR_W-1:0]),
    .count      (a_count),
    .reload_evt (a_reload_evt),
    .irq_evt    (a_irq_evt),
    .pin_out    (a_out)
  );

  mtab_chan_b #(
    .CNT_W (TMR_W)
  ) u_chan_b (
    .clk        (sys_clk),
    .rst_n      (rst_sync_n),
    .mode       (b_mode),
    .width_sel  (b_mode_ff[B_WIDTH_BIT]),
    .start      (start_ff[CH_B_BIT]),
    .edge_rise  (b_rise),
    .edge_fall  (b_fall),
    .load_wr    (b_load_wr),
    .load_data  (hwdata[TMR_W-1:0]),
    .count      (b_count),
    .reload     (b_reload),
    .reload_evt (b_reload_evt),
    .irq_evt    (b_irq_evt)
  );

  assign hrdata             = hrdata_ff;
  assign hreadyout          = hready_ff;
  assign hresp              = hresp_ff;
  assign timer_a_output_pin = a_out;
  assign irq                = irq_ff;

  a_reload_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    rd_go & sel_atmr & a_reload_evt & (a_mode == A_TIMER) |=> hrdata == RD_AT_UNDER)
    else $error("timer A read at reload did not give all ones");
  a_over_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    rd_go & sel_atmr & a_reload_evt & a_up |=> hrdata == RD_AT_OVER)
    else $error("event A read at overflow reload did not give zero");
  halted_write_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    a_load_wr & ~start_ff[CH_A_BIT] & ~(wr_go & sel_start) |=> a_count == $past(hwdata[15:0]))
    else $error("halted A write did not reach the counter");
  oneshot_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wr_go & sel_amode & a_from_cnt & (a_new_mode == A_ONESHOT) |=> irq_stat_ff[CH_A_BIT])
    else $error("one-shot selection did not set the A request");
  pwm_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wr_go & sel_amode & a_from_cnt & (a_new_mode == A_PWM) |=> irq_stat_ff[CH_A_BIT] ##1 irq_ff == irq_mask_ff[CH_A_BIT] | irq_ff)
    else $error("PWM selection did not set the A request");
  b_reload_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    rd_go & sel_btmr & b_reload_evt |=> hrdata == RD_AT_UNDER)
    else $error("timer B read at reload did not give all ones");
  meas_sel_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    b_sel_irq |=> irq_stat_ff[CH_B_BIT])
    else $error("measurement select change did not set the B request");
  sticky_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    irq_set[CH_A_BIT] |=> irq_stat_ff[CH_A_BIT])
    else $error("A event lost against a clear");

  // A halted B write reaches the counter at once
  b_halted_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    b_load_wr & ~start_ff[CH_B_BIT]
    |=> b_count == $past(hwdata[15:0]))
    else $error("halted B write did not reach the counter");
  // Reads off the reload cycle return the live count, except B in measurement
  a_live_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    rd_go & sel_atmr & ~a_reload_evt
    |=> hrdata == {16'h0, $past(a_count)})
    else $error("A read did not give the live count");
  b_live_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    rd_go & sel_btmr & ~b_reload_evt & (b_mode != B_MEAS)
    |=> hrdata == {16'h0, $past(b_count)})
    else $error("B read did not give the live count");
  // Measuring, the B register reads the captured value
  b_capture_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    rd_go & sel_btmr & (b_mode == B_MEAS)
    |=> hrdata == {16'h0, $past(b_reload)})
    else $error("B read in measurement missed the capture");

endmodule : mtab_timer

// [tb_multifunction_timer_ab.sv]
module tb_multifunction_timer_ab import mtab_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        a_event_pin;
  logic        b_event_pin;
  logic        timer_a_output_pin;
  logic        irq;
  logic [31:0] v1;
  logic [31:0] v2;
  int          miscompares;
  int          tests_run;

  mtab_timer dut (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hreadyout),
    .hrdata             (hrdata),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .a_event_pin        (a_event_pin),
    .b_event_pin        (b_event_pin),
    .timer_a_output_pin (timer_a_output_pin),
    .irq                (irq)
  );

  // Free running 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Value seen mid-cycle equals what the next rising edge samples
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 50 && r !== 1'b1; i++) begin
      @(negedge sys_clk);
      r = hreadyout;
      d = hrdata;
      @(posedge sys_clk);
    end
    if (r !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t bus handshake timed out", $time);
      end_of_test();
    end
  endtask : wait_rdy

  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic [31:0] junk;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy(junk);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] j;
    bus(1'b1, a, d, j);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h00000000, d);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, $sformatf("read of offset %h", a));
  endtask : rd_chk

  // Compares {output pin, irq} once the one-cycle irq lag has passed
  task automatic out_chk(input logic [1:0] exp);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({30'h0, timer_a_output_pin, irq}, {30'h0, exp}, "pin and irq");
    @(posedge sys_clk);
  endtask : out_chk

  // Event pulses held 4 cycles each side, well above the sync minimum
  task automatic pulse_a(input int n);
    for (int i = 0; i < n; i++) begin
      a_event_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      a_event_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask : pulse_a

  task automatic tend(input string name);
    $display("Test %s finished", name);
  endtask : tend

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    $display("[FAIL] %0t run limit reached", $time);
    end_of_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    a_event_pin = 1'b0;
    b_event_pin = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({31'h0, hresp}, 32'h00000000, "hresp");
    rd_chk(OFS_START, 32'h00000000);
    rd_chk(OFS_A_MODE, 32'h00000000);
    rd_chk(OFS_B_MODE, 32'h00000000);
    rd_chk(OFS_IRQ_STAT, 32'h00000000);
    rd_chk(OFS_IRQ_MASK, 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h00000000);
    wr(OFS_IRQ_MASK, 32'h00000003);
    rd_chk(OFS_IRQ_MASK, 32'h00000003);
    tend("reset and map");

    // Every listed route into one-shot and PWM raises the A request
    for (int s = 0; s < 2; s++) begin
      for (int t = 2; t < 4; t++) begin
        wr(OFS_A_MODE, 32'(s));
        wr(OFS_IRQ_STAT, 32'h00000003);
        wr(OFS_A_MODE, 32'(t));
        rd_chk(OFS_IRQ_STAT, 32'h00000001);
        out_chk(2'h1);
        wr(OFS_IRQ_STAT, 32'h00000001);
        rd_chk(OFS_IRQ_STAT, 32'h00000000);
      end
    end
    wr(OFS_A_MODE, 32'(A_TIMER));
    wr(OFS_A_MODE, 32'(A_ONESHOT));
    wr(OFS_IRQ_MASK, 32'h00000002);
    out_chk(2'h0);
    wr(OFS_IRQ_MASK, 32'h00000003);
    out_chk(2'h1);
    wr(OFS_IRQ_STAT, 32'h00000003);
    tend("mode change request");

    // One-shot stopped mid-count
    wr(OFS_A_TIMER, 32'h00000100);
    rd_chk(OFS_A_TIMER, 32'h00000100);
    wr(OFS_START, 32'h00000001);
    out_chk(2'h2);
    rd(OFS_A_TIMER, v1);
    chk({31'h0, v1 < 32'h00000100}, 32'h00000001, "one-shot counting");
    wr(OFS_START, 32'h00000000);
    out_chk(2'h1);
    rd_chk(OFS_IRQ_STAT, 32'h00000001);
    rd_chk(OFS_A_TIMER, 32'h00000100);
    wr(OFS_IRQ_STAT, 32'h00000003);
    tend("one-shot stop");

    // PWM stopped while high, then while low
    wr(OFS_A_MODE, 32'(A_PWM));
    wr(OFS_A_TIMER, 32'h00000200);
    wr(OFS_IRQ_STAT, 32'h00000003);
    wr(OFS_START, 32'h00000001);
    out_chk(2'h2);
    wr(OFS_START, 32'h00000000);
    out_chk(2'h1);
    rd_chk(OFS_IRQ_STAT, 32'h00000001);
    wr(OFS_A_TIMER, 32'h00000004);
    wr(OFS_IRQ_STAT, 32'h00000003);
    wr(OFS_START, 32'h00000001);
    repeat (20) @(posedge sys_clk);
    rd_chk(OFS_IRQ_STAT, 32'h00000001);
    wr(OFS_IRQ_STAT, 32'h00000003);
    wr(OFS_START, 32'h00000000);
    out_chk(2'h0);
    rd_chk(OFS_IRQ_STAT, 32'h00000000);
    tend("pwm stop");

    // Timer mode: reload value 0 makes every cycle a reload cycle
    wr(OFS_A_MODE, 32'(A_TIMER));
    wr(OFS_A_TIMER, 32'h00000000);
    wr(OFS_START, 32'h00000001);
    rd_chk(OFS_A_TIMER, 32'h0000FFFF);
    wr(OFS_START, 32'h00000000);
    wr(OFS_A_TIMER, 32'h00001000);
    rd_chk(OFS_A_TIMER, 32'h00001000);
    wr(OFS_START, 32'h00000001);
    rd(OFS_A_TIMER, v1);
    rd(OFS_A_TIMER, v2);
    chk({31'h0, v1 < 32'h00001000 && v2 < v1}, 32'h00000001, "live count");
    wr(OFS_START, 32'h00000000);
    tend("timer a readback");

    // Free-run event counter, counting down
    wr(OFS_A_MODE, 32'h00000009);
    wr(OFS_A_TIMER, 32'h00000005);
    wr(OFS_START, 32'h00000001);
    pulse_a(3);
    rd_chk(OFS_A_TIMER, 32'h00000002);
    wr(OFS_START, 32'h00000000);
    wr(OFS_A_TIMER, 32'h00000005);
    rd_chk(OFS_A_TIMER, 32'h00000005);
    // Reads landing on an event reload: down count, then up count
    for (int u = 0; u < 2; u++) begin
      wr(OFS_START, 32'h00000000);
      wr(OFS_A_MODE, (u == 0) ? 32'h00000001 : 32'h00000005);
      wr(OFS_A_TIMER, (u == 0) ? 32'h00000000 : 32'h0000FFFF);
      wr(OFS_START, 32'h00000001);
      // The synced edge meets the counter in the read's data phase
      a_event_pin <= 1'b1;
      @(posedge sys_clk);
      rd(OFS_A_TIMER, v1);
      a_event_pin <= 1'b0;
      chk(v1, {16'h0000, (u == 0) ? RD_AT_UNDER : RD_AT_OVER}, "event reload read");
      repeat (6) @(posedge sys_clk);
    end
    wr(OFS_IRQ_STAT, 32'h00000003);
    tend("event a");

    // B channel timer readback
    wr(OFS_B_TIMER, 32'h00000300);
    rd_chk(OFS_B_TIMER, 32'h00000300);
    wr(OFS_B_TIMER, 32'h00000000);
    wr(OFS_START, 32'h00000002);
    rd_chk(OFS_B_TIMER, 32'h0000FFFF);
    wr(OFS_START, 32'h00000000);
    wr(OFS_IRQ_STAT, 32'h00000003);
    tend("timer b readback");

    // Measurement: select change and first edge
    wr(OFS_B_MODE, 32'(B_MEAS));
    wr(OFS_START, 32'h00000002);
    wr(OFS_B_MODE, 32'h00000006);
    rd_chk(OFS_IRQ_STAT, 32'h00000002);
    wr(OFS_START, 32'h00000000);
    wr(OFS_B_MODE, 32'(B_MEAS));
    wr(OFS_IRQ_STAT, 32'h00000003);
    wr(OFS_START, 32'h00000002);
    b_event_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_chk(OFS_IRQ_STAT, 32'h00000000);
    out_chk(2'h0);
    wr(OFS_START, 32'h00000000);
    b_event_pin <= 1'b0;
    tend("measurement");
    end_of_test();
  end

endmodule : tb_multifunction_timer_ab
